// *** src/flip_pkg.sv ***
// Package: register map, field layout, vectors and carrier types of the interrupt priority block
package flip_pkg;
  // ==================================================
  // Register byte addresses on the APB bus
  localparam logic [11:0] ADDR_ENABLE_A = 12'h0A8;
  localparam logic [11:0] ADDR_ENABLE_B = 12'h0E8;
  localparam logic [11:0] ADDR_PRIO_LOWER = 12'h0B8;
  localparam logic [7:0] IDX_PRIO_UPPER = 8'hB7;
  localparam logic [11:0] ADDR_PRIO_UPPER = {2'h0, IDX_PRIO_UPPER, 2'h0};
  localparam logic [11:0] ADDR_STATUS = 12'h100;
  localparam logic [11:0] ADDR_CONFIG = 12'h104;
  // ==================================================
  // Reset values
  localparam logic [7:0] RST_ENABLE_A = 8'h00;
  localparam logic [7:0] RST_ENABLE_B = 8'h00;
  localparam logic [7:0] RST_PRIO_LOWER = 8'h00;
  localparam logic [7:0] RST_PRIO_UPPER = 8'h00;
  localparam logic [1:0] RST_CONFIG = 2'h0;
  // ==================================================
  // Field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int CFG_EXT0_EDGE_BIT = 0;
  localparam int CFG_EXT1_EDGE_BIT = 1;
  localparam int NUM_SRC = 9;
  localparam int NUM_LEVELS = 4;
  // Source index = polling order in the dual two-wire variant
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TW1 = 1;
  localparam int SRC_TW2 = 2;
  localparam int SRC_TIMER0 = 3;
  localparam int SRC_EXT1 = 4;
  localparam int SRC_TIMER1 = 5;
  localparam int SRC_UART = 6;
  localparam int SRC_TIMER2 = 7;
  localparam int SRC_ARRAY = 8;
  // Enable / priority register bit of each source; the two-wire bits are in enable_reg_b only, both share priority bit 7
  localparam int REG_BIT_EXT0 = 0;
  localparam int REG_BIT_TIMER0 = 1;
  localparam int REG_BIT_EXT1 = 2;
  localparam int REG_BIT_TIMER1 = 3;
  localparam int REG_BIT_UART = 4;
  localparam int REG_BIT_TIMER2 = 5;
  localparam int REG_BIT_ARRAY = 6;
  localparam int REG_BIT_TW1 = 0;
  localparam int REG_BIT_TW2 = 1;
  // ==================================================
  // Vector addresses
  localparam logic [7:0] VEC_EXT0 = 8'h03;
  localparam logic [7:0] VEC_TIMER0 = 8'h0B;
  localparam logic [7:0] VEC_EXT1 = 8'h13;
  localparam logic [7:0] VEC_TIMER1 = 8'h1B;
  localparam logic [7:0] VEC_UART = 8'h23;
  localparam logic [7:0] VEC_TW1 = 8'h2B;
  localparam logic [7:0] VEC_ARRAY = 8'h33;
  localparam logic [7:0] VEC_TIMER2 = 8'h3B;
  localparam logic [7:0] VEC_TW2 = 8'h43;

  // ==================================================
  // Carrier types
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } flip_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } flip_apb_rsp_t;

  typedef struct packed {
    logic [7:0] vector;
    logic [1:0] level;
    logic [3:0] source;
    logic valid;
  } flip_grant_t;
endpackage

// *** src/flip_level_mux.sv ***
// Level decode of one source from its two priority bits
`timescale 1ns/1ns
module flip_level_mux
  import flip_pkg::*;
(
  input wire logic upper_bit,
  input wire logic lower_bit,
  input wire logic active,
  output logic [3:0] level_onehot
);
  // Upper bit is the high bit of the level, so 11 is level 3
  always_comb begin
    level_onehot = 4'h0;
    if (active) begin
      level_onehot[{upper_bit, lower_bit}] = 1'b1;
    end
  end
endmodule

// *** src/flip_level_arb.sv ***
// Fixed-order arbiter: lowest index wins within one level
`timescale 1ns/1ns
module flip_level_arb
  import flip_pkg::*;
(
  input wire logic [8:0] req,
  output logic hit,
  output logic [3:0] idx
);
  // Scan from the highest index down so the smallest index is left standing
  always_comb begin
    hit = |req;
    idx = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
  end
endmodule

// *** src/flip_top.sv ***
// Four-level interrupt priority and vectoring block with APB registers
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module flip_top
  import flip_pkg::*;
#(
  parameter bit DUAL_TWO_WIRE = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire flip_pkg::flip_apb_req_t apb_req,
  output flip_pkg::flip_apb_rsp_t apb_rsp,
  input wire logic [8:0] src_request,
  input wire logic ext0_edge_event,
  input wire logic ext1_edge_event,
  input wire logic timer0_overflow_event,
  input wire logic timer1_overflow_event,
  input wire logic core_ack,
  input wire logic core_return,
  output flip_pkg::flip_grant_t grant,
  output logic ext0_request_flag,
  output logic ext1_request_flag,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag
);
  import flip_pkg::*;

  // ==================================================
  // State
  typedef struct packed {
    logic [7:0] enable_reg_a;
    logic [7:0] enable_reg_b;
    logic [7:0] priority_lower_bits;
    logic [7:0] priority_upper_bits;
    logic [1:0] config_bits;
    logic [3:0] active_levels;
    logic ext0_flag;
    logic ext1_flag;
    logic t0_flag;
    logic t1_flag;
    flip_grant_t grant;
    flip_apb_rsp_t rsp;
  } flip_state_t;

  flip_state_t state_reg;
  flip_state_t state_next;

  logic [8:0] raw_req;
  logic [8:0] src_en;
  logic [8:0] src_upper;
  logic [8:0] src_lower;
  logic [8:0] gated_req;
  logic [3:0] lvl_onehot [NUM_SRC];
  logic [8:0] req_at_level [NUM_LEVELS];
  logic [NUM_LEVELS-1:0] lvl_hit;
  logic [3:0] lvl_idx [NUM_LEVELS];
  logic win_valid;
  logic [1:0] win_level;
  logic [3:0] win_src;
  logic [7:0] win_vec;
  logic [3:0] blocking_mask;
  logic [1:0] top_active;
  logic bus_write;
  logic bus_read;

  // ==================================================
  // Request gathering; flag-backed sources use the block's own flags
  always_comb begin
    raw_req = src_request;
    raw_req[SRC_EXT0] = state_reg.config_bits[CFG_EXT0_EDGE_BIT] ? state_reg.ext0_flag
                                                               : src_request[SRC_EXT0];
    raw_req[SRC_EXT1] = state_reg.config_bits[CFG_EXT1_EDGE_BIT] ? state_reg.ext1_flag
                                                               : src_request[SRC_EXT1];
    raw_req[SRC_TIMER0] = state_reg.t0_flag;
    raw_req[SRC_TIMER1] = state_reg.t1_flag;
    raw_req[SRC_TW2] = DUAL_TWO_WIRE & src_request[SRC_TW2];
  end

  // Map register bits onto polling-ordered sources
  always_comb begin
    src_en = 9'h000;
    src_en[SRC_EXT0] = state_reg.enable_reg_a[REG_BIT_EXT0];
    src_en[SRC_TIMER0] = state_reg.enable_reg_a[REG_BIT_TIMER0];
    src_en[SRC_EXT1] = state_reg.enable_reg_a[REG_BIT_EXT1];
    src_en[SRC_TIMER1] = state_reg.enable_reg_a[REG_BIT_TIMER1];
    src_en[SRC_UART] = state_reg.enable_reg_a[REG_BIT_UART];
    src_en[SRC_TIMER2] = state_reg.enable_reg_a[REG_BIT_TIMER2];
    src_en[SRC_ARRAY] = state_reg.enable_reg_a[REG_BIT_ARRAY];
    src_en[SRC_TW1] = state_reg.enable_reg_b[REG_BIT_TW1];
    src_en[SRC_TW2] = state_reg.enable_reg_b[REG_BIT_TW2];
    src_upper = 9'h000;
    src_lower = 9'h000;
    src_upper[SRC_EXT0] = state_reg.priority_upper_bits[REG_BIT_EXT0];
    src_upper[SRC_TIMER0] = state_reg.priority_upper_bits[REG_BIT_TIMER0];
    src_upper[SRC_EXT1] = state_reg.priority_upper_bits[REG_BIT_EXT1];
    src_upper[SRC_TIMER1] = state_reg.priority_upper_bits[REG_BIT_TIMER1];
    src_upper[SRC_UART] = state_reg.priority_upper_bits[REG_BIT_UART];
    src_upper[SRC_TIMER2] = state_reg.priority_upper_bits[REG_BIT_TIMER2];
    src_upper[SRC_ARRAY] = state_reg.priority_upper_bits[REG_BIT_ARRAY];
    src_upper[SRC_TW1] = state_reg.priority_upper_bits[7];
    src_upper[SRC_TW2] = state_reg.priority_upper_bits[7];
    src_lower[SRC_EXT0] = state_reg.priority_lower_bits[REG_BIT_EXT0];
    src_lower[SRC_TIMER0] = state_reg.priority_lower_bits[REG_BIT_TIMER0];
    src_lower[SRC_EXT1] = state_reg.priority_lower_bits[REG_BIT_EXT1];
    src_lower[SRC_TIMER1] = state_reg.priority_lower_bits[REG_BIT_TIMER1];
    src_lower[SRC_UART] = state_reg.priority_lower_bits[REG_BIT_UART];
    src_lower[SRC_TIMER2] = state_reg.priority_lower_bits[REG_BIT_TIMER2];
    src_lower[SRC_ARRAY] = state_reg.priority_lower_bits[REG_BIT_ARRAY];
    src_lower[SRC_TW1] = state_reg.priority_lower_bits[7];
    src_lower[SRC_TW2] = state_reg.priority_lower_bits[7];
  end

  // Individual and global enable gate every request
  assign gated_req = raw_req & src_en & {NUM_SRC{state_reg.enable_reg_a[GLOBAL_EN_BIT]}};

  // ==================================================
  // Level decode and per-level arbitration
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    flip_level_mux u_mux (
      .upper_bit(src_upper[s]),
      .lower_bit(src_lower[s]),
      .active(gated_req[s]),
      .level_onehot(lvl_onehot[s])
    );
  end

  for (genvar l = 0; l < NUM_LEVELS; l++) begin : g_lvl
    always_comb begin
      for (int s = 0; s < NUM_SRC; s++) begin
        req_at_level[l][s] = lvl_onehot[s][l];
      end
    end
    flip_level_arb u_arb (
      .req(req_at_level[l]),
      .hit(lvl_hit[l]),
      .idx(lvl_idx[l])
    );
  end

  // Highest active level, and the levels that block new requests
  always_comb begin
    top_active = 2'h0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (state_reg.active_levels[l]) begin
        top_active = 2'(l);
      end
    end
    blocking_mask = 4'h0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      blocking_mask[l] = (|state_reg.active_levels) && (2'(l) <= top_active);
    end
  end

  // Highest requesting level that is not blocked wins
  always_comb begin
    win_valid = 1'b0;
    win_level = 2'h0;
    win_src = 4'h0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (lvl_hit[l] && !blocking_mask[l]) begin
        win_valid = 1'b1;
        win_level = 2'(l);
        win_src = lvl_idx[l];
      end
    end
  end

  // Vector table in polling order
  always_comb begin
    unique case (win_src)
      4'h0: win_vec = VEC_EXT0;
      4'h1: win_vec = VEC_TW1;
      4'h2: win_vec = VEC_TW2;
      4'h3: win_vec = VEC_TIMER0;
      4'h4: win_vec = VEC_EXT1;
      4'h5: win_vec = VEC_TIMER1;
      4'h6: win_vec = VEC_UART;
      4'h7: win_vec = VEC_TIMER2;
      4'h8: win_vec = VEC_ARRAY;
      default: win_vec = VEC_EXT0;
    endcase
  end

  // ==================================================
  // Next state: APB registers, flags, service stack, grant
  assign bus_write = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign bus_read = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

  always_comb begin
    state_next = state_reg;
    state_next.rsp.pready = 1'b1;
    state_next.rsp.pslverr = 1'b0;
    // Events set flags; a set in the cycle of a clear wins by coming last
    if (bus_write) begin
      unique case (apb_req.paddr)
        ADDR_ENABLE_A: state_next.enable_reg_a = apb_req.pwdata[7:0];
        ADDR_ENABLE_B: state_next.enable_reg_b = apb_req.pwdata[7:0];
        ADDR_PRIO_LOWER: state_next.priority_lower_bits = apb_req.pwdata[7:0];
        ADDR_PRIO_UPPER: state_next.priority_upper_bits = apb_req.pwdata[7:0];
        ADDR_CONFIG: state_next.config_bits = apb_req.pwdata[1:0];
        ADDR_STATUS: begin
          state_next.ext0_flag = state_reg.ext0_flag & ~apb_req.pwdata[0];
          state_next.ext1_flag = state_reg.ext1_flag & ~apb_req.pwdata[1];
          state_next.t0_flag = state_reg.t0_flag & ~apb_req.pwdata[2];
          state_next.t1_flag = state_reg.t1_flag & ~apb_req.pwdata[3];
        end
        default: state_next.rsp.pslverr = 1'b0;
      endcase
    end
    // Read data is captured in the setup cycle, valid in the access cycle
    if (bus_read) begin
      state_next.rsp.prdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        ADDR_ENABLE_A: state_next.rsp.prdata[7:0] = state_reg.enable_reg_a;
        ADDR_ENABLE_B: state_next.rsp.prdata[7:0] = state_reg.enable_reg_b;
        ADDR_PRIO_LOWER: state_next.rsp.prdata[7:0] = state_reg.priority_lower_bits;
        ADDR_PRIO_UPPER: state_next.rsp.prdata[7:0] = state_reg.priority_upper_bits;
        ADDR_CONFIG: state_next.rsp.prdata[1:0] = state_reg.config_bits;
        ADDR_STATUS: state_next.rsp.prdata[11:0] = {state_reg.active_levels,
          state_reg.t1_flag, state_reg.t0_flag, state_reg.ext1_flag, state_reg.ext0_flag,
          2'h0, state_reg.grant.level};
        default: state_next.rsp.prdata = 32'h0000_0000;
      endcase
    end
    // Return pops the top level so the preempted service resumes
    if (core_return && |state_reg.active_levels) begin
      state_next.active_levels[top_active] = 1'b0;
    end
    // Core takes the vector: push its level and clear hardware flags
    if (core_ack && state_reg.grant.valid) begin
      state_next.active_levels[state_reg.grant.level] = 1'b1;
      unique case (state_reg.grant.source)
        // External flags clear only in edge mode; in level mode the pin is the request
        4'(SRC_EXT0): begin
          if (state_reg.config_bits[CFG_EXT0_EDGE_BIT]) state_next.ext0_flag = 1'b0;
        end
        4'(SRC_EXT1): begin
          if (state_reg.config_bits[CFG_EXT1_EDGE_BIT]) state_next.ext1_flag = 1'b0;
        end
        4'(SRC_TIMER0): state_next.t0_flag = 1'b0;
        4'(SRC_TIMER1): state_next.t1_flag = 1'b0;
        default: state_next.t1_flag = state_next.t1_flag;
      endcase
    end
    if (ext0_edge_event) state_next.ext0_flag = 1'b1;
    if (ext1_edge_event) state_next.ext1_flag = 1'b1;
    if (timer0_overflow_event) state_next.t0_flag = 1'b1;
    if (timer1_overflow_event) state_next.t1_flag = 1'b1;
    // Grant re-evaluates each cycle; drop it the cycle it is taken
    state_next.grant.valid = win_valid && !(core_ack && state_reg.grant.valid);
    state_next.grant.level = win_level;
    state_next.grant.source = win_src;
    state_next.grant.vector = win_vec;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.enable_reg_a <= RST_ENABLE_A;
      state_reg.enable_reg_b <= RST_ENABLE_B;
      state_reg.priority_lower_bits <= RST_PRIO_LOWER;
      state_reg.priority_upper_bits <= RST_PRIO_UPPER;
      state_reg.config_bits <= RST_CONFIG;
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp = state_reg.rsp;
  assign grant = state_reg.grant;
  assign ext0_request_flag = state_reg.ext0_flag;
  assign ext1_request_flag = state_reg.ext1_flag;
  assign timer0_overflow_flag = state_reg.t0_flag;
  assign timer1_overflow_flag = state_reg.t1_flag;

  // ==================================================
  // Checks
  // A level in service is never offered again until its return pops it
  chk_grant_level_blocked: assert property (@(posedge sys_clk)
    disable iff (!arst_n) grant.valid |-> !state_reg.active_levels[grant.level])
    else $error("grant at blocked level");
  // With the global enable off nothing is granted on the next cycle
  chk_global_gate: assert property (@(posedge sys_clk)
    disable iff (!arst_n) !state_reg.enable_reg_a[GLOBAL_EN_BIT] |=> !grant.valid)
    else $error("grant with global enable off");
  // Timer flags clear on vectoring unless a new overflow lands in that cycle
  chk_timer0_clear: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (core_ack && grant.valid && grant.source == 4'(SRC_TIMER0) && !timer0_overflow_event)
      |=> !timer0_overflow_flag)
    else $error("timer0 flag not cleared on vector");
  chk_timer1_clear: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (core_ack && grant.valid && grant.source == 4'(SRC_TIMER1) && !timer1_overflow_event)
      |=> !timer1_overflow_flag)
    else $error("timer1 flag not cleared on vector");
  // In level mode the pin carries the request, so vectoring leaves the flag alone
  chk_level_keeps_ext0: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (core_ack && grant.valid && grant.source == 4'(SRC_EXT0) && ext0_request_flag
      && !state_reg.config_bits[CFG_EXT0_EDGE_BIT] && !bus_write) |=> ext0_request_flag)
    else $error("level mode ext0 flag cleared on vector");
  // Taking a vector pushes its level; a return pops only the top level
  chk_push_level: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (core_ack && grant.valid && !core_return) |=> state_reg.active_levels[$past(grant.level)])
    else $error("service level not pushed");
  chk_return_pop: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (core_return && !core_ack && |state_reg.active_levels)
      |=> (state_reg.active_levels | (4'h1 << $past(top_active)))
        == $past(state_reg.active_levels) && !state_reg.active_levels[$past(top_active)])
    else $error("return did not pop exactly the top level");
  // Vector table spot checks
  chk_vector_ext0: assert property (@(posedge sys_clk)
    disable iff (!arst_n) (grant.valid && grant.source == 4'h0) |-> grant.vector == 8'h03)
    else $error("wrong ext0 vector");
  chk_vector_tw1: assert property (@(posedge sys_clk)
    disable iff (!arst_n) (grant.valid && grant.source == 4'h1) |-> grant.vector == 8'h2B)
    else $error("wrong first two-wire vector");
  chk_vector_tw2: assert property (@(posedge sys_clk)
    disable iff (!arst_n) (grant.valid && grant.source == 4'h2) |-> grant.vector == 8'h43)
    else $error("wrong second two-wire vector");
  // The single variant never offers the second two-wire unit
  chk_tw2_masked: assert property (@(posedge sys_clk)
    disable iff (!arst_n) (!DUAL_TWO_WIRE && grant.valid) |-> grant.source != 4'(SRC_TW2))
    else $error("masked two-wire unit granted");
  // A nested grant always outranks every level in service
  chk_preempt_higher: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (grant.valid && |state_reg.active_levels) |-> grant.level > top_active)
    else $error("nested grant not higher than active level");
  // With nothing in service, a winner is offered on the next cycle
  chk_idle_service: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (win_valid && state_reg.active_levels == 4'h0 && !core_ack) |=> grant.valid)
    else $error("idle request not granted");
endmodule

// *** tb/flip_core_model.sv ***
// CPU core model: takes presented grants and signals service returns
`timescale 1ns/1ns
module flip_core_model
  import flip_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire flip_pkg::flip_grant_t grant,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  input wire logic ret_req,
  output logic core_ack,
  output logic core_return,
  output logic [7:0] taken_vec,
  output logic [7:0] taken_cnt
);
  logic [3:0] wait_cnt;
  // ==================================================
  // Acknowledge after ack_wait cycles; a slow core leaves the grant standing meanwhile
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_ack <= 1'b0;
      core_return <= 1'b0;
      taken_vec <= 8'h00;
      taken_cnt <= 8'h00;
      wait_cnt <= 4'h0;
    end else begin
      core_ack <= 1'b0;
      core_return <= ret_req; // One-cycle return pulse
      if (core_ack && grant.valid) begin
        taken_vec <= grant.vector;
        taken_cnt <= taken_cnt + 8'h01;
        wait_cnt <= 4'h0;
      end else if (ack_en && grant.valid && !core_ack) begin
        if (wait_cnt == ack_wait) begin
          core_ack <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0; // Otherwise restart the wait count for the next grant
      end
    end
  end
endmodule

// *** tb/tb_flip_top.sv ***
// Self-checking testbench of the interrupt priority block
`timescale 1ns/1ns
module tb_flip_top;
  import flip_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  flip_apb_req_t apb_req = '0;
  flip_apb_rsp_t apb_rsp;
  flip_grant_t grant;
  flip_grant_t grant_single;
  logic [8:0] src_request = 9'h000;
  logic ext0_ev = 1'b0;
  logic ext1_ev = 1'b0;
  logic t0_ev = 1'b0;
  logic t1_ev = 1'b0;
  logic core_ack, core_return, f_e0, f_e1, f_t0, f_t1;
  logic ack_en = 1'b0;
  logic ret_req = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic [7:0] taken_vec, taken_cnt;
  logic [31:0] rd;
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] exp_vec [9] = '{VEC_EXT0, VEC_TW1, VEC_TW2, VEC_TIMER0, VEC_EXT1,
                             VEC_TIMER1, VEC_UART, VEC_TIMER2, VEC_ARRAY};
  int nest_src [4] = '{SRC_EXT0, SRC_TIMER2, SRC_UART, SRC_ARRAY};
  // ==================================================
  // Clock and instances
  always #50 sys_clk = ~sys_clk;
  flip_top u_flip_top (.sys_clk(sys_clk), .arst_n(arst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .src_request(src_request), .ext0_edge_event(ext0_ev),
    .ext1_edge_event(ext1_ev), .timer0_overflow_event(t0_ev),
    .timer1_overflow_event(t1_ev), .core_ack(core_ack), .core_return(core_return),
    .grant(grant), .ext0_request_flag(f_e0), .ext1_request_flag(f_e1),
    .timer0_overflow_flag(f_t0), .timer1_overflow_flag(f_t1));
  flip_core_model u_flip_core_model (.sys_clk(sys_clk), .arst_n(arst_n), .grant(grant),
    .ack_en(ack_en), .ack_wait(ack_wait), .ret_req(ret_req), .core_ack(core_ack),
    .core_return(core_return), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
  // Single two-wire build on the same bus and requests; never acknowledged, only watched
  if (1'h1) begin : g_single
    flip_top #(.DUAL_TWO_WIRE(1'b0)) u_flip_top (.sys_clk(sys_clk), .arst_n(arst_n),
      .apb_req(apb_req), .apb_rsp(), .src_request(src_request), .ext0_edge_event(ext0_ev),
      .ext1_edge_event(ext1_ev), .timer0_overflow_event(t0_ev),
      .timer1_overflow_event(t1_ev), .core_ack(1'b0), .core_return(1'b0),
      .grant(grant_single), .ext0_request_flag(), .ext1_request_flag(),
      .timer0_overflow_flag(), .timer1_overflow_flag());
  end
  // ==================================================
  // Report and comparison
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask
  // ==================================================
  // APB master: request held until pready is sampled high
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      results();
    end
    rd = apb_rsp.prdata;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb_xfer(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic act_chk(input logic [3:0] e);
    apb_xfer(1'b0, ADDR_STATUS, 32'h0);
    check(32'(rd[11:8]), 32'(e));
  endtask
  // ==================================================
  // Grant side helpers; every wait is bounded
  task automatic wait_grant(input int s, input logic [1:0] l);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (grant.valid !== 1'b1 && n < 30);
    if (n >= 30) begin
      bad_count++;
      results();
    end
    check(32'(grant.vector), 32'(exp_vec[s]));
    check(32'(grant.source), s);
    check(32'(grant.level), 32'(l));
  endtask
  task automatic quiet(input int n);
    logic any;
    any = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #1;
      if (grant.valid !== 1'b0) any = 1'b1;
    end
    check(32'(any), 32'h0);
  endtask
  task automatic take();
    logic [7:0] c;
    int n;
    c = taken_cnt;
    n = 0;
    @(posedge sys_clk);
    ack_en <= 1'b1;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (taken_cnt === c && n < 30);
    if (n >= 30) begin
      bad_count++;
      results();
    end
    @(posedge sys_clk);
    ack_en <= 1'b0;
  endtask
  task automatic ret();
    @(posedge sys_clk);
    ret_req <= 1'b1;
    @(posedge sys_clk);
    ret_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // ==================================================
  // Hang guard
  initial begin
    #(100000 * 100);
    bad_count++;
    results();
  end
  // ==================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Reset values, one unmapped place, upper-bit register write and read back
    rdchk(ADDR_ENABLE_A, 32'h0);
    rdchk(ADDR_ENABLE_B, 32'h0);
    rdchk(ADDR_PRIO_LOWER, 32'h0);
    rdchk(ADDR_PRIO_UPPER, 32'h0);
    wr(ADDR_PRIO_UPPER, 32'hFFFF_FFA5);
    rdchk(12'h0B7 << 2, 32'h0000_00A5);
    wr(12'h200, 32'hFFFF_FFFF);
    rdchk(12'h200, 32'h0);
    check(32'(apb_rsp.pslverr), 32'h0);
    wr(ADDR_PRIO_UPPER, 32'h0);
    // Global and individual enables both gate a request
    src_request[SRC_UART] <= 1'b1;
    wr(ADDR_ENABLE_A, 32'h0000_007F);
    quiet(8);
    wr(ADDR_ENABLE_A, 32'h0000_0080);
    quiet(8);
    wr(ADDR_ENABLE_A, 32'h0000_0090);
    wait_grant(SRC_UART, 2'h0);
    src_request <= 9'h000;
    // All nine sources at level 0 at once: served in polling order
    wr(ADDR_ENABLE_A, 32'h0000_00FF);
    wr(ADDR_ENABLE_B, 32'h0000_0003);
    @(posedge sys_clk);
    src_request <= 9'h1D7;
    ext0_ev <= 1'b1;
    ext1_ev <= 1'b1;
    t0_ev <= 1'b1;
    t1_ev <= 1'b1;
    @(posedge sys_clk);
    ext0_ev <= 1'b0;
    ext1_ev <= 1'b0;
    t0_ev <= 1'b0;
    t1_ev <= 1'b0;
    #1;
    check(32'({f_e0, f_e1, f_t0, f_t1}), 32'hF);
    for (int k = 0; k < NUM_SRC; k++) begin
      wait_grant(k, 2'h0);
      take();
      src_request[k] <= 1'b0;
      if (k == SRC_EXT0) check(32'(f_e0), 32'h1);
      if (k == SRC_EXT1) check(32'(f_e1), 32'h1);
      if (k == SRC_TIMER0) check(32'(f_t0), 32'h0);
      if (k == SRC_TIMER1) check(32'(f_t1), 32'h0);
      ret();
    end
    // Edge mode external request: flag set by the event, cleared on vectoring
    wr(ADDR_CONFIG, 32'h0000_0001);
    @(posedge sys_clk);
    ext0_ev <= 1'b1;
    @(posedge sys_clk);
    ext0_ev <= 1'b0;
    #1;
    check(32'(f_e0), 32'h1);
    wait_grant(SRC_EXT0, 2'h0);
    take();
    check(32'(f_e0), 32'h0);
    ret();
    wr(ADDR_CONFIG, 32'h0);
    // Nesting: levels 0..3 preempt in turn, slow core, then unwind
    wr(ADDR_PRIO_LOWER, 32'h0000_0060);
    wr(ADDR_PRIO_UPPER, 32'h0000_0050);
    ack_wait <= 4'h3;
    for (int k = 0; k < NUM_LEVELS; k++) begin
      src_request[nest_src[k]] <= 1'b1;
      wait_grant(nest_src[k], 2'(k));
      take();
      if (k > 0) src_request[nest_src[k]] <= 1'b0;
    end
    act_chk(4'hF);
    for (int k = 3; k > 0; k--) begin
      ret();
      act_chk(4'((1 << k) - 1));
      quiet(4);
    end
    ret();
    wait_grant(SRC_EXT0, 2'h0);
    take();
    src_request <= 9'h000;
    ret();
    act_chk(4'h0);
    // Status write clears the flags; the single build ignores the second two-wire unit
    wr(ADDR_STATUS, 32'h0000_000F);
    #1;
    check(32'({f_e0, f_e1, f_t0, f_t1}), 32'h0);
    src_request[SRC_TW2] <= 1'b1;
    wait_grant(SRC_TW2, 2'h0);
    check(32'(grant_single.valid), 32'h0);
    src_request <= 9'h006;
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'({grant_single.valid, grant_single.vector}), 32'h12B);
    results();
  end
endmodule
